/* File: verilog/txr_tx_ring_queue.sv */
// Queue 1 transmit descriptor ring: registers, prefetch engine and on-chip descriptor buffer.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Upper base address word held, 32 bits
// - Length bits 6:0 ignored, read zero
// - Length field stored in bits 19:7
// - Hardware advances 16-bit head per descriptor
// - 16-bit tail marks end of work
// - Process descriptors from head up to tail
// - Prefetch considered when on-chip below threshold
// - Prefetch needs host count at host threshold
// - Thresholds in cache lines or descriptors
// - Reserved upper pointer/length bits read zero
// - Bit 24 selects descriptor units when set
// - Prefetch waits for higher priority DMA
// - Low base address bits 3:0 read zero
module txr_tx_ring_queue (
  // Clock and synchronous reset.
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // AXI4-Lite register slave.
  input wire txr_pkg::txr_axi_req_t I_AXI,
  output txr_pkg::txr_axi_rsp_t O_AXI,
  // Descriptor fetch request to host memory.
  output txr_pkg::txr_fetch_t O_FETCH,
  input wire logic I_FETCH_READY,
  // Fetched descriptors returning from host memory.
  input wire logic I_DESC_VALID,
  input wire logic [`TXR_DESC_W-1:0] I_DESC_DATA,
  output logic O_DESC_READY,
  // Descriptors handed to the transmit engine.
  output logic O_TXD_VALID,
  output logic [`TXR_DESC_W-1:0] O_TXD_DATA,
  input wire logic I_TXD_READY,
  // Higher priority DMA activity pending.
  input wire logic I_DMA_BUSY
);
  import txr_pkg::*;

  localparam logic [`TXR_CNT_W-1:0] FIFO_DEPTH = `TXR_CNT_W'(`TXR_FIFO_DEPTH);

  txr_state_t s;
  txr_state_t next_s;

  logic awready;
  logic wready;
  logic arready;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic [`TXR_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [`TXR_ADDR_W-1:0] wr_word;
  logic [`TXR_ADDR_W-1:0] rd_word;
  logic [`TXR_PTR_W-1:0] entries;
  logic [`TXR_PTR_W-1:0] head_next;
  logic [`TXR_PTR_W-1:0] fetch_next;
  logic [`TXR_PTR_W-1:0] host_count;
  logic [`TXR_PTR_W-1:0] to_end;
  logic [`TXR_PTR_W-1:0] onchip;
  logic [`TXR_PTR_W-1:0] onchip_units;
  logic [`TXR_PTR_W-1:0] host_units;
  logic [`TXR_PTR_W-1:0] req_count;
  logic [`TXR_CNT_W-1:0] fifo_count;
  logic [`TXR_CNT_W-1:0] free_slots;
  logic fifo_flush;
  logic desc_fire;
  logic txd_fire;
  logic want_fetch;
  logic threshold_units_select_desc;

  // Merges written bytes into the old value and clears bits outside the mask.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return m & mask;
  endfunction : merge

  // Handshake outputs come straight from the holding state; data outputs are registered.
  assign awready = !s.aw_held && !s.bvalid;
  assign wready = !s.w_held && !s.bvalid;
  assign arready = !s.rvalid;
  assign aw_fire = I_AXI.awvalid && awready;
  assign w_fire = I_AXI.wvalid && wready;
  assign ar_fire = I_AXI.arvalid && arready;
  assign do_write = (s.aw_held || aw_fire) && (s.w_held || w_fire) && !s.bvalid;
  assign wr_addr = s.aw_held ? s.awaddr : I_AXI.awaddr;
  assign wr_data = s.w_held ? s.wdata : I_AXI.wdata;
  assign wr_strb = s.w_held ? s.wstrb : I_AXI.wstrb;
  assign wr_word = wr_addr & `TXR_ALIGN_MASK;
  assign rd_word = I_AXI.araddr & `TXR_ALIGN_MASK;

  always_comb begin
    O_AXI.awready = awready;
    O_AXI.wready = wready;
    O_AXI.bvalid = s.bvalid;
    O_AXI.bresp = s.bresp;
    O_AXI.arready = arready;
    O_AXI.rvalid = s.rvalid;
    O_AXI.rdata = s.rdata;
    O_AXI.rresp = s.rresp;
  end

  // The fetch request stands from its registered address until the memory side takes it.
  always_comb begin
    O_FETCH.valid = (s.fst == TXR_REQ);
    O_FETCH.addr = s.freq_addr;
    O_FETCH.count = s.freq_count;
  end

  // Ring size in entries is the byte length divided by the descriptor size.
  assign entries = `TXR_PTR_W'(s.len[`TXR_LEN_MSB:`TXR_DESC_SHIFT]);

  // Pointer steppers for the processing head and the fetch position.
  txr_ring_step u_head_step (
    .i_ptr(s.head),
    .i_entries(entries),
    .o_next(head_next)
  );

  txr_ring_step u_fetch_step (
    .i_ptr(s.fetch_ptr),
    .i_entries(entries),
    .o_next(fetch_next)
  );

  // On-chip descriptor buffer; its ready is the back-pressure toward host memory.
  txr_fifo #(
    .WIDTH(`TXR_DESC_W),
    .DEPTH(`TXR_FIFO_DEPTH)
  ) u_desc_fifo (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_flush(fifo_flush),
    .i_valid(I_DESC_VALID),
    .i_data(I_DESC_DATA),
    .o_ready(O_DESC_READY),
    .o_valid(O_TXD_VALID),
    .o_data(O_TXD_DATA),
    .i_ready(I_TXD_READY),
    .o_count(fifo_count)
  );

  assign desc_fire = I_DESC_VALID && O_DESC_READY;
  assign txd_fire = O_TXD_VALID && I_TXD_READY;

  // A head rewrite or a transmit reset invalidates every on-chip descriptor.
  assign fifo_flush = do_write && ((wr_word == `TXR_OFF_HEAD) ||
                      ((wr_word == `TXR_OFF_QCTL) && wr_strb[0] &&
                       wr_data[`TXR_QCTL_RST_BIT]));

  // Descriptors waiting in host memory lie from the fetch position up to the tail.
  always_comb begin
    if (s.tail >= s.fetch_ptr) begin
      host_count = s.tail - s.fetch_ptr;
    end else begin
      host_count = entries - s.fetch_ptr + s.tail;
    end
    to_end = entries - s.fetch_ptr;
  end

  // Threshold comparison in descriptor or cache-line units.
  always_comb begin
    threshold_units_select_desc = s.dctl[`TXR_THRESHOLD_UNITS_SELECT_BIT];
    onchip = `TXR_PTR_W'(fifo_count) + `TXR_PTR_W'(s.outstanding);
    free_slots = FIFO_DEPTH - fifo_count - s.outstanding;
    if (threshold_units_select_desc) begin
      onchip_units = onchip;
      host_units = host_count;
    end else begin
      onchip_units = onchip >> `TXR_LINE_SHIFT;
      host_units = host_count >> `TXR_LINE_SHIFT;
    end
  end

  // Prefetch only below the on-chip threshold, with enough host work and a quiet bus.
  always_comb begin
    want_fetch = s.enable && (free_slots != '0) && (host_count != '0) &&
                 (onchip_units < `TXR_PTR_W'(s.dctl[`TXR_PTH_MSB:`TXR_PTH_LSB])) &&
                 (host_units >= `TXR_PTR_W'(s.dctl[`TXR_HTH_MSB:`TXR_HTH_LSB])) &&
                 !I_DMA_BUSY;
    req_count = host_count;
    if (req_count > to_end) begin
      req_count = to_end;
    end
    if (req_count > `TXR_PTR_W'(free_slots)) begin
      req_count = `TXR_PTR_W'(free_slots);
    end
  end

  // Next state: register slave, pointer tracking and fetch sequencing.
  always_comb begin
    next_s = s;

    // Write channel capture; address and data may arrive in either order.
    if (aw_fire && !do_write) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = I_AXI.awaddr;
    end
    if (w_fire && !do_write) begin
      next_s.w_held = 1'b1;
      next_s.wdata = I_AXI.wdata;
      next_s.wstrb = I_AXI.wstrb;
    end
    if (s.bvalid && I_AXI.bready) begin
      next_s.bvalid = 1'b0;
    end

    // Hardware pointer motion: one entry per descriptor handed on.
    if (txd_fire) begin
      next_s.head = head_next;
    end
    if (desc_fire && (s.outstanding != '0)) begin
      next_s.outstanding = next_s.outstanding - `TXR_CNT_W'(1);
    end

    // Fetch sequencer.
    case (s.fst)
      TXR_IDLE: begin
        if (want_fetch) begin
          next_s.freq_addr = {s.base_hi, s.base_lo} +
                             {44'h0, s.fetch_ptr, 4'h0};
          next_s.freq_count = req_count[`TXR_CNT_W-1:0];
          next_s.fst = TXR_REQ;
        end
      end
      TXR_REQ: begin
        if (I_FETCH_READY) begin
          next_s.outstanding = next_s.outstanding + s.freq_count;
          next_s.fetch_ptr = s.fetch_ptr + `TXR_PTR_W'(s.freq_count);
          if (next_s.fetch_ptr >= entries) begin
            next_s.fetch_ptr = `TXR_PTR_ZERO;
          end
          next_s.fst = TXR_WAIT;
        end
      end
      TXR_WAIT: begin
        if (next_s.outstanding == '0) begin
          next_s.fst = TXR_IDLE;
        end
      end
      default: begin
        next_s.fst = TXR_IDLE;
      end
    endcase

    // Register write, with the response one cycle after both halves are in.
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `TXR_RESP_OKAY;
      if (wr_word == `TXR_OFF_BASE_LO) begin
        next_s.base_lo = merge(s.base_lo, wr_data, wr_strb, `TXR_MASK_BASE_LO);
      end else if (wr_word == `TXR_OFF_BASE_HI) begin
        next_s.base_hi = merge(s.base_hi, wr_data, wr_strb, `TXR_MASK_BASE_HI);
      end else if (wr_word == `TXR_OFF_LEN) begin
        next_s.len = merge(s.len, wr_data, wr_strb, `TXR_MASK_LEN);
      end else if (wr_word == `TXR_OFF_HEAD) begin
        // Rewriting the head restarts fetching from there and drops buffered work.
        next_s.head = `TXR_PTR_W'(merge(32'(s.head), wr_data, wr_strb, `TXR_MASK_PTR));
        next_s.fetch_ptr = next_s.head;
        next_s.outstanding = '0;
      end else if (wr_word == `TXR_OFF_TAIL) begin
        next_s.tail = `TXR_PTR_W'(merge(32'(s.tail), wr_data, wr_strb,
                                        `TXR_MASK_PTR));
      end else if (wr_word == `TXR_OFF_DCTL) begin
        next_s.dctl = merge(s.dctl, wr_data, wr_strb, `TXR_MASK_DCTL);
      end else if (wr_word == `TXR_OFF_QCTL) begin
        if (wr_strb[0]) begin
          next_s.enable = wr_data[`TXR_QCTL_EN_BIT];
          if (wr_data[`TXR_QCTL_RST_BIT]) begin
            // Transmit reset clears the ring state but keeps base and thresholds.
            next_s.head = `TXR_PTR_ZERO;
            next_s.tail = `TXR_PTR_ZERO;
            next_s.len = '0;
            next_s.fetch_ptr = `TXR_PTR_ZERO;
            next_s.outstanding = '0;
            next_s.fst = TXR_IDLE;
            next_s.enable = 1'b0;
          end
        end
      end else if (wr_word == `TXR_OFF_QSTAT) begin
        next_s.bresp = `TXR_RESP_OKAY;
      end else begin
        next_s.bresp = `TXR_RESP_SLVERR;
      end
    end

    // Register read; the answer is registered and stands until rready.
    if (s.rvalid && I_AXI.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `TXR_RESP_OKAY;
      next_s.rdata = '0;
      if (rd_word == `TXR_OFF_BASE_LO) begin
        next_s.rdata = s.base_lo;
      end else if (rd_word == `TXR_OFF_BASE_HI) begin
        next_s.rdata = s.base_hi;
      end else if (rd_word == `TXR_OFF_LEN) begin
        next_s.rdata = s.len;
      end else if (rd_word == `TXR_OFF_HEAD) begin
        next_s.rdata = 32'(s.head);
      end else if (rd_word == `TXR_OFF_TAIL) begin
        next_s.rdata = 32'(s.tail);
      end else if (rd_word == `TXR_OFF_DCTL) begin
        next_s.rdata = s.dctl;
      end else if (rd_word == `TXR_OFF_QCTL) begin
        next_s.rdata[`TXR_QCTL_EN_BIT] = s.enable;
      end else if (rd_word == `TXR_OFF_QSTAT) begin
        next_s.rdata[`TXR_QSTAT_CNT_MSB:`TXR_QSTAT_CNT_LSB] = fifo_count;
        next_s.rdata[`TXR_QSTAT_FST_MSB:`TXR_QSTAT_FST_LSB] = s.fst;
        next_s.rdata[`TXR_QSTAT_EN_BIT] = s.enable;
      end else begin
        next_s.rresp = `TXR_RESP_SLVERR;
      end
    end
  end

  // State register; device reset clears everything, pointers and length included.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : txr_tx_ring_queue
`default_nettype wire

/* File: shared/txr_tx_ring_map.svh */
// Register offsets, field positions, masks and sizes of the queue 1 transmit ring block.
`ifndef TXR_TX_RING_MAP_SVH
`define TXR_TX_RING_MAP_SVH

// Register byte offsets on the AXI4-Lite slave.
`define TXR_ADDR_W 16
`define TXR_ALIGN_MASK 16'hFFFC
`define TXR_OFF_BASE_LO 16'h3900
`define TXR_OFF_BASE_HI 16'h3904
`define TXR_OFF_LEN 16'h3908
`define TXR_OFF_HEAD 16'h3910
`define TXR_OFF_TAIL 16'h3918
`define TXR_OFF_DCTL 16'h3928
`define TXR_OFF_QCTL 16'h3930
`define TXR_OFF_QSTAT 16'h3934

// Writable bit masks; bits outside a mask are stored and read as zero.
`define TXR_MASK_BASE_LO 32'hFFFFFFF0
`define TXR_MASK_BASE_HI 32'hFFFFFFFF
`define TXR_MASK_LEN 32'h000FFF80
`define TXR_MASK_PTR 32'h0000FFFF
`define TXR_MASK_DCTL 32'hFF3FFF3F

// Field positions.
`define TXR_LEN_LSB 7
`define TXR_LEN_MSB 19
`define TXR_PTH_LSB 0
`define TXR_PTH_MSB 5
`define TXR_HTH_LSB 8
`define TXR_HTH_MSB 15
`define TXR_THRESHOLD_UNITS_SELECT_BIT 24
`define TXR_QCTL_EN_BIT 0
`define TXR_QCTL_RST_BIT 1
`define TXR_QSTAT_CNT_LSB 0
`define TXR_QSTAT_CNT_MSB 2
`define TXR_QSTAT_FST_LSB 4
`define TXR_QSTAT_FST_MSB 5
`define TXR_QSTAT_EN_BIT 8

// Sizes: descriptors are 16 bytes, a cache line holds four of them.
`define TXR_DESC_W 128
`define TXR_DESC_SHIFT 4
`define TXR_LINE_SHIFT 2
`define TXR_FIFO_DEPTH 4
`define TXR_CNT_W 3
`define TXR_PTR_W 16
`define TXR_PTR_ONE 16'h0001
`define TXR_PTR_ZERO 16'h0000

// AXI responses.
`define TXR_RESP_OKAY 2'b00
`define TXR_RESP_SLVERR 2'b10

`endif

/* File: shared/txr_pkg.sv */
// Types shared by the transmit ring block and its bench.
package txr_pkg;
  `include "txr_tx_ring_map.svh"

  // Descriptor fetch engine states, Gray coded along idle, request, wait.
  typedef enum logic [1:0] {
    TXR_IDLE = 2'b00,
    TXR_REQ = 2'b01,
    TXR_WAIT = 2'b11
  } txr_fetch_state_t;

  // AXI4-Lite signals driven by the master.
  typedef struct packed {
    logic awvalid;
    logic [`TXR_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`TXR_ADDR_W-1:0] araddr;
    logic rready;
  } txr_axi_req_t;

  // AXI4-Lite signals driven by the slave.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } txr_axi_rsp_t;

  // Descriptor read request to host memory.
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
    logic [`TXR_CNT_W-1:0] count;
  } txr_fetch_t;

  // Whole state of the top module.
  typedef struct packed {
    logic aw_held;
    logic [`TXR_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] base_lo;
    logic [31:0] base_hi;
    logic [31:0] len;
    logic [`TXR_PTR_W-1:0] head;
    logic [`TXR_PTR_W-1:0] tail;
    logic [31:0] dctl;
    logic enable;
    logic [`TXR_PTR_W-1:0] fetch_ptr;
    logic [`TXR_CNT_W-1:0] outstanding;
    txr_fetch_state_t fst;
    logic [63:0] freq_addr;
    logic [`TXR_CNT_W-1:0] freq_count;
  } txr_state_t;
endpackage : txr_pkg

/* File: verilog/txr_ring_step.sv */
// Advance of a ring pointer by one entry with wrap at the ring end.
`timescale 1ns/10ps
`default_nettype none
module txr_ring_step (
  // Pointer and ring size in descriptor entries.
  input wire logic [15:0] i_ptr,
  input wire logic [15:0] i_entries,
  // Next pointer.
  output logic [15:0] o_next
);
  import txr_pkg::*;

  logic [15:0] plus_one;

  // An empty ring or the last entry both return to entry zero.
  always_comb begin
    plus_one = i_ptr + `TXR_PTR_ONE;
    if (plus_one >= i_entries) begin
      o_next = `TXR_PTR_ZERO;
    end else begin
      o_next = plus_one;
    end
  end
endmodule : txr_ring_step
`default_nettype wire

/* File: verilog/txr_fifo.sv */
// Small synchronous FIFO with flush, valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module txr_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 4
) (
  // Clock and synchronous reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  // Filling side.
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Draining side.
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready,
  // Fill level.
  output logic [$clog2(DEPTH):0] o_count
);
  import txr_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic push;
  logic pop;

  // Ready and valid follow the true fill level, so the source feels back-pressure.
  assign o_ready = (s.count != CNT_FULL);
  assign o_valid = (s.count != '0);
  assign o_data = s.mem[s.rd];
  assign o_count = s.count;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Pointer and level update; a flush drops every stored word.
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = i_data;
      next_s.wr = s.wr + PTR_ONE;
    end
    if (pop) begin
      next_s.rd = s.rd + PTR_ONE;
    end
    if (push && !pop) begin
      next_s.count = s.count + CNT_ONE;
    end else if (pop && !push) begin
      next_s.count = s.count - CNT_ONE;
    end
    if (i_flush) begin
      next_s.wr = '0;
      next_s.rd = '0;
      next_s.count = '0;
    end
  end

  // State register.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : txr_fifo
`default_nettype wire

/* File: sim/txr_tx_ring_properties.sv */
// Port checker for the queue 1 transmit descriptor ring block.
`timescale 1ns/10ps
`default_nettype none
module txr_tx_ring_properties (
  // Clock and reset.
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Watched ports.
  input wire txr_pkg::txr_axi_req_t I_AXI,
  input wire txr_pkg::txr_axi_rsp_t O_AXI,
  input wire txr_pkg::txr_fetch_t O_FETCH,
  input wire logic I_FETCH_READY,
  input wire logic O_TXD_VALID,
  input wire logic [127:0] O_TXD_DATA,
  input wire logic I_TXD_READY,
  input wire logic I_DMA_BUSY
);
  logic [15:0] rd_addr;
  // Word address of the read in flight, to judge its data.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_AXI.arvalid && O_AXI.arready) begin
      rd_addr <= I_AXI.araddr & 16'hFFFC;
    end
  end
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);
  property p_fetch_hold;
    O_FETCH.valid && !I_FETCH_READY |=> O_FETCH.valid && $stable(O_FETCH.addr)
      && $stable(O_FETCH.count);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch request changed");
  property p_fetch_count;
    O_FETCH.valid |-> O_FETCH.count inside {[3'h1:3'h4]};
  endproperty
  a_fetch_count: assert property (p_fetch_count) else $error("fetch count out of range");
  property p_fetch_align;
    O_FETCH.valid |-> O_FETCH.addr[3:0] == 4'h0;
  endproperty
  a_fetch_align: assert property (p_fetch_align) else $error("fetch address unaligned");
  property p_busy_blocks;
    $rose(O_FETCH.valid) |-> !$past(I_DMA_BUSY);
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("fetch began while busy");
  // A write may flush the buffer, so stalls during one are not judged.
  property p_txd_hold;
    O_TXD_VALID && !I_TXD_READY && !I_AXI.wvalid && !I_AXI.awvalid
      |=> O_TXD_VALID && $stable(O_TXD_DATA);
  endproperty
  a_txd_hold: assert property (p_txd_hold) else $error("descriptor dropped on stall");
  property p_write_resp;
    I_AXI.awvalid && O_AXI.awready && I_AXI.wvalid && O_AXI.wready
      |=> O_AXI.bvalid && !O_AXI.awready;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write not answered");
  property p_len_zero;
    O_AXI.rvalid && rd_addr == 16'h3908 |-> O_AXI.rdata[6:0] == 7'h00
      && O_AXI.rdata[31:20] == 12'h000;
  endproperty
  a_len_zero: assert property (p_len_zero) else $error("length low bits not zero");
  property p_ptr_upper;
    O_AXI.rvalid && (rd_addr == 16'h3910 || rd_addr == 16'h3918)
      |-> O_AXI.rdata[31:16] == 16'h0000;
  endproperty
  a_ptr_upper: assert property (p_ptr_upper) else $error("pointer upper bits set");
endmodule : txr_tx_ring_properties
bind txr_tx_ring_queue txr_tx_ring_properties i_props (.I_SYS_CLK(I_SYS_CLK),
  .I_RST_N(I_RST_N), .I_AXI(I_AXI), .O_AXI(O_AXI), .O_FETCH(O_FETCH),
  .I_FETCH_READY(I_FETCH_READY), .O_TXD_VALID(O_TXD_VALID), .O_TXD_DATA(O_TXD_DATA),
  .I_TXD_READY(I_TXD_READY), .I_DMA_BUSY(I_DMA_BUSY));
`default_nettype wire

/* File: sim/txr_host_mem_model.sv */
// Behavioural host memory that answers descriptor fetch requests.
`timescale 1ns/10ps
`default_nettype none
module txr_host_mem_model (
  // Clock, reset and pacing.
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_slow,
  // Fetch requests.
  input wire txr_pkg::txr_fetch_t i_fetch,
  output logic o_ready,
  // Returned descriptors.
  output logic o_valid,
  output logic [127:0] o_data,
  input wire logic i_ready
);
  logic [63:0] cur;
  int left, lag;
  // Beats carry their own address; idle data lines toggle, as nothing holds them.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_valid <= 1'b0;
      o_data <= '0;
      left = 0;
      lag = 0;
    end else begin
      if (!o_valid || i_ready) begin
        if (left != 0) begin
          o_valid <= 1'b1;
          o_data <= {cur, ~cur};
          cur = cur + 64'h10;
          left = left - 1;
        end else begin
          o_valid <= 1'b0;
          o_data <= ~o_data;
        end
      end
      if (i_fetch.valid && o_ready) begin
        cur = i_fetch.addr;
        left = int'(i_fetch.count);
        o_ready <= 1'b0;
        lag = 0;
      end else begin
        lag = i_fetch.valid ? lag + 1 : 0;
        o_ready <= i_fetch.valid && (!i_slow || lag > 3);
      end
    end
  end
endmodule : txr_host_mem_model
`default_nettype wire

/* File: sim/test_tx_descriptor_ring_queue.sv */
// Self-checking bench of the queue 1 transmit descriptor ring block.
`timescale 1ns/10ps
`default_nettype none
module test_tx_descriptor_ring_queue;
  import txr_pkg::*;
  logic I_SYS_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  txr_axi_req_t I_AXI = '0;
  txr_axi_rsp_t O_AXI;
  txr_fetch_t O_FETCH;
  logic I_FETCH_READY, I_DESC_VALID, O_DESC_READY, O_TXD_VALID;
  logic [127:0] I_DESC_DATA, O_TXD_DATA;
  logic I_TXD_READY = 1'b0, I_DMA_BUSY = 1'b0, slow = 1'b0;
  logic [31:0] rd;
  logic [1:0] rsp;
  int fails = 0;
  int n_checks = 0;

  // Clock of 20 ns period.
  always #10 I_SYS_CLK = ~I_SYS_CLK;

  txr_tx_ring_queue i_dut (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_AXI(I_AXI),
    .O_AXI(O_AXI), .O_FETCH(O_FETCH), .I_FETCH_READY(I_FETCH_READY),
    .I_DESC_VALID(I_DESC_VALID), .I_DESC_DATA(I_DESC_DATA), .O_DESC_READY(O_DESC_READY),
    .O_TXD_VALID(O_TXD_VALID), .O_TXD_DATA(O_TXD_DATA), .I_TXD_READY(I_TXD_READY),
    .I_DMA_BUSY(I_DMA_BUSY));
  txr_host_mem_model i_mem (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N), .i_slow(slow),
    .i_fetch(O_FETCH), .o_ready(I_FETCH_READY), .o_valid(I_DESC_VALID),
    .o_data(I_DESC_DATA), .i_ready(O_DESC_READY));

  task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : check_word

  task automatic check_desc(input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected descriptor address: expected %h seen %h", e, g);
      fails++;
    end
  endtask : check_desc

  // Write: address and data offered together, each released once taken.
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
    logic ta, tw, b;
    @(posedge I_SYS_CLK);
    I_AXI.awvalid <= 1'b1;
    I_AXI.awaddr <= a;
    I_AXI.wvalid <= 1'b1;
    I_AXI.wdata <= d;
    I_AXI.wstrb <= 4'hF;
    I_AXI.bready <= 1'b1;
    do begin
      @(negedge I_SYS_CLK);
      ta = I_AXI.awvalid & O_AXI.awready;
      tw = I_AXI.wvalid & O_AXI.wready;
      b = O_AXI.bvalid;
      rsp = O_AXI.bresp;
      @(posedge I_SYS_CLK);
      if (ta) I_AXI.awvalid <= 1'b0;
      if (tw) I_AXI.wvalid <= 1'b0;
      if (b) I_AXI.bready <= 1'b0;
    end while (b !== 1'b1);
  endtask : axi_wr

  // Read one word and compare it.
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic ta, r;
    @(posedge I_SYS_CLK);
    I_AXI.arvalid <= 1'b1;
    I_AXI.araddr <= a;
    I_AXI.rready <= 1'b1;
    do begin
      @(negedge I_SYS_CLK);
      ta = I_AXI.arvalid & O_AXI.arready;
      r = O_AXI.rvalid;
      rd = O_AXI.rdata;
      rsp = O_AXI.rresp;
      @(posedge I_SYS_CLK);
      if (ta) I_AXI.arvalid <= 1'b0;
      if (r) I_AXI.rready <= 1'b0;
    end while (r !== 1'b1);
    check_word($sformatf("register %h", a), e, rd);
  endtask : rd_chk

  // Take n descriptors, expecting entries from idx on, wrapping at 8.
  task automatic take(input int n, input int idx);
    int got = 0, k = 0;
    I_TXD_READY <= 1'b1;
    while (got < n && k < 400) begin
      @(negedge I_SYS_CLK);
      if (O_TXD_VALID === 1'b1) begin
        check_desc({32'h000000A5, 32'h00001000 + 32'(16 * idx)}, O_TXD_DATA[127:64]);
        idx = (idx + 1) % 8;
        got++;
      end
      @(posedge I_SYS_CLK);
      k++;
    end
    I_TXD_READY <= 1'b0;
    check_word("descriptors taken", n, got);
  endtask : take

  task automatic t_reset;
    rd_chk(16'h3908, 32'h0);
    rd_chk(16'h3910, 32'h0);
    rd_chk(16'h3918, 32'h0);
    rd_chk(16'h3A00, 32'h0);
    check_word("unmapped response", 32'h2, {30'h0, rsp});
    axi_wr(16'h3A00, 32'h1);
    check_word("unmapped write", 32'h2, {30'h0, rsp});
    $display("test reset done");
  endtask : t_reset

  task automatic t_masks;
    logic [15:0] adr [6] = '{16'h3900, 16'h3904, 16'h3908, 16'h3910, 16'h3918, 16'h3928};
    logic [31:0] ex [6] = '{32'hFFFFFFF0, 32'hFFFFFFFF, 32'h000FFF80, 32'h0000FFFF,
      32'h0000FFFF, 32'hFF3FFF3F};
    for (int i = 0; i < 6; i++) begin
      axi_wr(adr[i], 32'hFFFFFFFF);
      rd_chk(adr[i], ex[i]);
      axi_wr(adr[i], 32'h0);
      rd_chk(adr[i], 32'h0);
    end
    $display("test masks done");
  endtask : t_masks

  // Ring of 8 entries; thresholds in lines first, then in descriptors.
  task automatic t_thresh;
    axi_wr(16'h3900, 32'h00001000);
    axi_wr(16'h3904, 32'h000000A5);
    axi_wr(16'h3908, 32'h00000080);
    axi_wr(16'h3928, 32'h00000108);
    axi_wr(16'h3930, 32'h1);
    axi_wr(16'h3918, 32'h2);
    repeat (30) @(posedge I_SYS_CLK);
    rd_chk(16'h3934, 32'h00000100);
    axi_wr(16'h3928, 32'h01000108);
    take(2, 0);
    rd_chk(16'h3910, 32'h2);
    axi_wr(16'h3928, 32'h01000100);
    axi_wr(16'h3918, 32'h4);
    repeat (30) @(posedge I_SYS_CLK);
    rd_chk(16'h3934, 32'h00000100);
    $display("test thresholds done");
  endtask : t_thresh

  // Busy blocks fetching; then a slow memory fills the buffer.
  task automatic t_fill;
    I_DMA_BUSY <= 1'b1;
    axi_wr(16'h3928, 32'h01000108);
    repeat (30) @(posedge I_SYS_CLK);
    rd_chk(16'h3934, 32'h00000100);
    slow <= 1'b1;
    I_DMA_BUSY <= 1'b0;
    axi_wr(16'h3918, 32'h0);
    repeat (80) @(posedge I_SYS_CLK);
    rd_chk(16'h3934, 32'h00000104);
    check_word("ready when full", 32'h0, {31'h0, O_DESC_READY});
    take(6, 2);
    repeat (20) @(posedge I_SYS_CLK);
    rd_chk(16'h3910, 32'h0);
    check_word("valid at tail", 32'h0, {31'h0, O_TXD_VALID});
    $display("test fill done");
  endtask : t_fill

  task automatic t_txreset;
    axi_wr(16'h3930, 32'h0);
    axi_wr(16'h3918, 32'h5);
    rd_chk(16'h3918, 32'h5);
    axi_wr(16'h3930, 32'h2);
    rd_chk(16'h3908, 32'h0);
    rd_chk(16'h3910, 32'h0);
    rd_chk(16'h3918, 32'h0);
    rd_chk(16'h3904, 32'h000000A5);
    $display("test transmit reset done");
  endtask : t_txreset

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge I_SYS_CLK);
    I_RST_N <= 1'b1;
    t_reset();
    t_masks();
    t_thresh();
    t_fill();
    t_txreset();
    report_and_stop();
  end

  // Watchdog far beyond the tests' length.
  initial begin
    repeat (20000) @(posedge I_SYS_CLK);
    fails++;
    report_and_stop();
  end
endmodule : test_tx_descriptor_ring_queue
`default_nettype wire
